// ---- src/csrw_pkg.sv ----
/*
  shared constants and types for the csr write-side bus slave and its master end.
  assumes a single bus clock and a synchronous active-high reset.
*/
package csrw_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int PROT_W = 3;
  localparam int RESP_W = 2;
  localparam int BYTE_W = 8;
  localparam int NUM_REGS = 16;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 4;
  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
  localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;
  localparam logic [DATA_W-1:0] REG_INIT = 32'h0000_0000;
  typedef logic [ADDR_W-1:0] csrw_addr_t;
  typedef logic [DATA_W-1:0] csrw_data_t;
  typedef logic [STRB_W-1:0] csrw_strb_t;
  typedef logic [RESP_W-1:0] csrw_resp_t;
  typedef enum logic [1:0] {CSRW_IDLE, CSRW_BUSY, CSRW_RESP} csrw_mst_state_t;
endpackage : csrw_pkg

// ---- src/csrw_if.sv ----
/*
  write-channel carrier between the csr write slave and its master.
  assumes both ends share clk_sys; the testbench drives clk and reset.
*/
`timescale 1ns/1ps
`default_nettype none
interface csrw_if (
  input wire logic clk_sys,
  input wire logic reset
);
  import csrw_pkg::*;
  csrw_addr_t awaddr;
  logic [PROT_W-1:0] awprot;
  logic awvalid;
  logic awready;
  csrw_data_t wdata;
  csrw_strb_t wstrb;
  logic wvalid;
  logic wready;
  csrw_resp_t bresp;
  logic bvalid;
  logic bready;
  modport slave (
    input clk_sys, reset, awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
    output awready, wready, bresp, bvalid
  );
  modport master (
    input clk_sys, reset, awready, wready, bresp, bvalid,
    output awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready
  );
endinterface : csrw_if
`default_nettype wire

// ---- src/csrw_slave.sv ----
/*
  write-side slave: takes the address, then data in the same cycle or later, merges bytes
  into a register array and answers on the response channel.
  assumes a master that keeps the channel handshake rules; one write in flight.
*/
// Notes on behaviour
// [R01] reset returns all registers to initial value
// [R02] write address is six-bit byte address
// [R03] master holds awvalid and address until accepted
// [R04] protection field accepted but ignored
// [R05] address captured when awvalid and awready high
// [R06] master holds 32-bit data until wready
// [R07] four strobe bits, bit0 lowest byte
// [R08] data stored on w handshake after address
// [R09] master raises wvalid only with valid data
// [R10] response codes okay, exokay, slverr, decerr
// [R11] bvalid held until master raises bready
// [R12] master raises bready when able to accept
// [R13] wready high when data can be accepted
// [R14] unstrobed bytes keep their old value
// [R15] every completed write answers okay
`timescale 1ns/1ps
`default_nettype none
module csrw_slave (
  csrw_if.slave bus,
  output logic [csrw_pkg::NUM_REGS*csrw_pkg::DATA_W-1:0] regs_flat
);
  import csrw_pkg::*;

  function automatic csrw_data_t merge_bytes(csrw_data_t old, csrw_data_t nw, csrw_strb_t s);
    csrw_data_t m;
    m = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (s[i]) begin
        m[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W]; // [R07] [R14]
      end
    end
    return m;
  endfunction : merge_bytes

  csrw_data_t regs_r [NUM_REGS];
  csrw_addr_t addr_r;
  logic addr_ok_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  csrw_resp_t bresp_r;

  // prot reaches no logic, so no write depends on it [R04]
  wire aw_hs = bus.awvalid && awready_r; // [R05]
  wire w_hs = bus.wvalid && wready_r;
  wire have_addr = addr_ok_r || aw_hs; // [R08]
  wire do_write = w_hs && have_addr; // [R08]
  wire csrw_addr_t wr_addr = addr_ok_r ? addr_r : bus.awaddr; // [R02]
  wire [IDX_W-1:0] wr_idx = wr_addr[IDX_LSB +: IDX_W];
  wire b_done = bvalid_r && bus.bready;
  // new writes wait until the previous response is gone
  wire idle = !bvalid_r;

  always_ff @(posedge bus.clk_sys) begin
    if (bus.reset) begin
      addr_r <= '0;
      addr_ok_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (do_write) begin
        addr_ok_r <= 1'b0;
      end else if (aw_hs) begin
        addr_ok_r <= 1'b1;
        addr_r <= bus.awaddr; // [R05]
      end
      awready_r <= idle && !addr_ok_r && !aw_hs && !do_write;
      wready_r <= idle && !w_hs && !do_write; // [R13]
      if (do_write) begin
        bvalid_r <= 1'b1; // [R11]
        bresp_r <= RESP_OKAY; // [R10] [R15]
      end else if (b_done) begin
        bvalid_r <= 1'b0; // [R11]
      end
    end
  end

  // data taken before its address is not supported; wready waits for the address
  always_ff @(posedge bus.clk_sys) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (bus.reset) begin
        regs_r[i] <= REG_INIT; // [R01]
      end else if (do_write && wr_idx == IDX_W'(i)) begin
        regs_r[i] <= merge_bytes(regs_r[i], bus.wdata, bus.wstrb); // [R08]
      end
    end
  end

  always_ff @(posedge bus.clk_sys) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_flat[i*DATA_W +: DATA_W] <= regs_r[i];
    end
  end

  assign bus.awready = awready_r;
  assign bus.wready = wready_r && have_addr;
  assign bus.bvalid = bvalid_r;
  assign bus.bresp = bresp_r;
endmodule : csrw_slave
`default_nettype wire

// ---- src/csrw_master.sv ----
/*
  write-side master: takes one write request from user logic, drives the
  address and data channels and returns the response code.
  assumes a slave that answers every accepted write with a response.
*/
`timescale 1ns/1ps
`default_nettype none
module csrw_master (
  csrw_if.master bus,
  input wire logic req,
  input wire csrw_pkg::csrw_addr_t req_addr,
  input wire csrw_pkg::csrw_data_t req_data,
  input wire csrw_pkg::csrw_strb_t req_strb,
  input wire logic [csrw_pkg::PROT_W-1:0] req_prot,
  output logic busy,
  output logic done,
  output csrw_pkg::csrw_resp_t resp
);
  import csrw_pkg::*;

  csrw_mst_state_t state_r;
  csrw_addr_t awaddr_r;
  csrw_data_t wdata_r;
  csrw_strb_t wstrb_r;
  logic awvalid_r;
  logic wvalid_r;
  logic bready_r;
  logic [PROT_W-1:0] awprot_r;

  wire start = (state_r == CSRW_IDLE) && req;
  wire aw_hs = awvalid_r && bus.awready;
  wire w_hs = wvalid_r && bus.wready;
  wire b_hs = bready_r && bus.bvalid;
  wire aw_left = awvalid_r && !aw_hs;
  wire w_left = wvalid_r && !w_hs;

  always_ff @(posedge bus.clk_sys) begin
    if (bus.reset) begin
      state_r <= CSRW_IDLE;
      awvalid_r <= 1'b0;
      wvalid_r <= 1'b0;
      bready_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awprot_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      resp <= RESP_OKAY;
    end else begin
      done <= 1'b0;
      case (state_r)
        CSRW_IDLE: begin
          if (start) begin
            awaddr_r <= req_addr;
            wdata_r <= req_data;
            wstrb_r <= req_strb;
            awprot_r <= req_prot;
            awvalid_r <= 1'b1; // [R03]
            wvalid_r <= 1'b1; // [R06] [R09]
            busy <= 1'b1;
            state_r <= CSRW_BUSY;
          end
        end
        CSRW_BUSY: begin
          awvalid_r <= aw_left; // [R03]
          wvalid_r <= w_left; // [R06]
          if (!aw_left && !w_left) begin
            bready_r <= 1'b1; // [R12]
            state_r <= CSRW_RESP;
          end
        end
        CSRW_RESP: begin
          if (b_hs) begin
            bready_r <= 1'b0;
            resp <= bus.bresp; // [R10]
            done <= 1'b1;
            busy <= 1'b0;
            state_r <= CSRW_IDLE;
          end
        end
        default: state_r <= CSRW_IDLE;
      endcase
    end
  end

  assign bus.awaddr = awaddr_r;
  // user logic chooses the protection bits so the slave can be shown to ignore them
  assign bus.awprot = awprot_r; // [R04]
  assign bus.awvalid = awvalid_r;
  assign bus.wdata = wdata_r;
  assign bus.wstrb = wstrb_r;
  assign bus.wvalid = wvalid_r;
  assign bus.bready = bready_r;
endmodule : csrw_master
`default_nettype wire

// ---- bench/csrw_monitor.sv ----
/* write-channel checks beside the interface.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module csrw_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire csrw_pkg::csrw_resp_t bresp,
  input wire logic bvalid,
  input wire logic bready
);
  import csrw_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_data_take;
    wvalid && wready;
  endsequence
  sequence s_resp_take;
    bvalid && bready;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !bvalid && !awready && !wready)
    else $error("channel active after reset");
  a_aw_drop: assert property (awvalid && awready |=> !awready)
    else $error("awready kept after address taken");
  a_resp_follows: assert property (s_data_take |=> bvalid && !wready)
    else $error("no response after data");
  a_bvalid_cause: assert property ($rose(bvalid) |-> $past(wvalid && wready))
    else $error("response without data");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("response dropped early");
  a_bresp_okay: assert property (bvalid |-> bresp == RESP_OKAY)
    else $error("response code not okay");
  a_no_take_busy: assert property (bvalid |-> !awready && !wready)
    else $error("ready during response");
  // the slave sees its own response gone one cycle later, so awready returns after that
  a_ready_return: assert property (s_resp_take |=> !bvalid ##1 awready)
    else $error("ready not back after response");
endmodule : csrw_monitor
`default_nettype wire

// ---- bench/tb.sv ----
/* bench: master and slave joined, corner and random writes.
   assumes done pulses once per write. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csrw_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  csrw_addr_t a = '0;
  csrw_data_t d = '0;
  csrw_strb_t s = '0;
  logic [PROT_W-1:0] p = '0;
  logic busy, done;
  csrw_resp_t resp;
  logic [NUM_REGS*DATA_W-1:0] regs_flat;
  csrw_data_t exp_r [NUM_REGS];
  int miscompares = 0, n_checks = 0, cyc = 0;
  integer seed = 42;
  csrw_if csrw_if_i (.clk_sys(clk_sys), .reset(reset));
  csrw_slave csrw_slave_i (.bus(csrw_if_i.slave), .regs_flat(regs_flat));
  csrw_master csrw_master_i (.bus(csrw_if_i.master), .req(req), .req_addr(a), .req_data(d),
    .req_strb(s), .req_prot(p), .busy(busy), .done(done), .resp(resp));
  csrw_monitor csrw_monitor_i (.clk_sys(clk_sys), .reset(reset), .awvalid(csrw_if_i.awvalid),
    .awready(csrw_if_i.awready), .wvalid(csrw_if_i.wvalid), .wready(csrw_if_i.wready),
    .bresp(csrw_if_i.bresp), .bvalid(csrw_if_i.bvalid), .bready(csrw_if_i.bready));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  function automatic csrw_data_t merge(csrw_data_t o, csrw_data_t n, csrw_strb_t m);
    for (int b = 0; b < STRB_W; b++)
      if (m[b]) o[b*BYTE_W+:BYTE_W] = n[b*BYTE_W+:BYTE_W];
    return o;
  endfunction : merge
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: value mismatch", $time);
    end
  endtask : chk
  // next request is raised in the done cycle, so writes run back to back
  task automatic wr(input csrw_addr_t na, input csrw_data_t nd, input csrw_strb_t ns);
    int n;
    n = 0;
    a = na;
    d = nd;
    s = ns;
    p = PROT_W'($random(seed));
    req = 1'b1;
    do begin
      tick();
      n++;
    end while (busy !== 1'b1 && n < 20);
    req = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    // a write that never finishes counts here, not only at the cycle ceiling
    chk(done === 1'b1);
    chk(busy === 1'b0);
    exp_r[na[ADDR_W-1:IDX_LSB]] = merge(exp_r[na[ADDR_W-1:IDX_LSB]], nd, ns);
    chk(resp === RESP_OKAY);
    for (int i = 0; i < NUM_REGS; i++) chk(regs_flat[i*DATA_W+:DATA_W] === exp_r[i]);
  endtask : wr
  task automatic summarize;
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    foreach (exp_r[i]) exp_r[i] = REG_INIT;
    repeat (5) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    wr(6'h04, 32'h1234_5678, 4'hf);
    wr(6'h07, 32'hffff_ffff, 4'h0);
    for (int b = 0; b < STRB_W; b++) wr(6'h3d, 32'h8bad_f00d ^ b, 4'h1 << b);
    repeat (40) wr(csrw_addr_t'($random(seed)), $random(seed), csrw_strb_t'($random(seed)));
    reset = 1'b1;
    tick();
    tick();
    reset = 1'b0;
    foreach (exp_r[i]) exp_r[i] = REG_INIT;
    wr(6'h3f, 32'h0, 4'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
